// file: inc/acqseq_pkg.sv
package acqseq_pkg;
	localparam int NUM_INST = 8;
	localparam int NUM_SECT = 3;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 5;
	localparam int CH_W = 3;
	localparam int PTR_W = 2;
	localparam int IDX_W = 3;
	localparam int TIMER_W = 16;
	localparam int ACQ_CYCLES_DEF = 4;
	// instruction section 0 fields
	localparam int LOOP_BIT = 0;
	localparam int PAUSE_BIT = 1;
	localparam int POS_LSB = 2;
	localparam int NEG_LSB = 5;
	localparam int SYNC_BIT = 8;
	localparam int TIMER_BIT = 9;
	localparam int RES_BIT = 10;
	localparam int WDOG_BIT = 11;
	// configuration register fields
	localparam int CFG_START = 0;
	localparam int CFG_RESET = 1;
	localparam int CFG_SYNC_DIR = 7;
	localparam int CFG_PTR_LSB = 8;
	localparam logic [PTR_W-1:0] PTR_CTRL = 2'h0;
	localparam logic [PTR_W-1:0] PTR_LIM1 = 2'h1;
	localparam logic [PTR_W-1:0] PTR_LIM2 = 2'h2;
	localparam logic [PTR_W-1:0] PTR_NONE = 2'h3;
	// device word map (word = address lines 4 to 1)
	localparam logic [3:0] WORD_INST_MAX = 4'h7;
	localparam logic [3:0] WORD_CFG = 4'h8;
	localparam logic [3:0] WORD_TIMER = 4'h9;
	localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
	localparam logic [IDX_W-1:0] IDX_FIRST = 3'h0;
	// host controller register map (axi4-lite byte offsets)
	localparam logic [7:0] HOST_CTRL = 8'h00;
	localparam logic [7:0] HOST_WDATA = 8'h04;
	localparam logic [7:0] HOST_GO = 8'h08;
	localparam logic [7:0] HOST_STATUS = 8'h0c;
	localparam logic [7:0] HOST_RDATA = 8'h10;
	localparam int HC_WE_BIT = 8;
	localparam int HC_BW_BIT = 9;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: inc/acqseq_if.sv
`timescale 1ns/10ps
interface acqseq_if;
	import acqseq_pkg::*;
	logic bus_req;
	logic bus_we;
	logic [ADDR_W-1:0] host_address_lines;
	logic byte_wide_bus_select;
	logic [DATA_W-1:0] bus_wdata;
	logic [DATA_W-1:0] bus_rdata;
	logic bus_ack;
	modport dev (
		input bus_req,
		input bus_we,
		input host_address_lines,
		input byte_wide_bus_select,
		input bus_wdata,
		output bus_rdata,
		output bus_ack
	);
	modport host (
		output bus_req,
		output bus_we,
		output host_address_lines,
		output byte_wide_bus_select,
		output bus_wdata,
		input bus_rdata,
		input bus_ack
	);
endinterface

// file: rtl/acqseq_device.sv
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module acqseq_device
	import acqseq_pkg::*;
	#(parameter int ACQ_CYCLES = ACQ_CYCLES_DEF)
	(
	input wire logic aclk,
	input wire logic aresetn,
	acqseq_if.dev bus,
	input wire logic sync_in,
	output logic sync_out,
	output logic sync_oe,
	output logic pause_irq,
	output logic conv_req,
	output logic [CH_W-1:0] conv_pos_input,
	output logic [CH_W-1:0] conv_neg_input,
	output logic conv_res_8bit,
	output logic conv_compare,
	output logic conv_limit_sel,
	output logic [DATA_W-1:0] conv_limit,
	input wire logic conv_done,
	output logic running
	);

	typedef enum logic [2:0] {
		S_FETCH, S_WAIT, S_EXEC, S_TIMER, S_ACQ, S_SYNC, S_CONV, S_NEXT
	} acqseq_state_e;

	logic [DATA_W-1:0] ram [0:NUM_INST-1][0:NUM_SECT-1];
	acqseq_state_e state;
	logic [IDX_W-1:0] idx;
	logic [DATA_W-1:0] cur;
	logic armed;
	logic start;
	logic sync_dir;
	logic [PTR_W-1:0] ptr;
	logic [TIMER_W-1:0] timer_preset;
	logic [TIMER_W-1:0] timer_cnt;
	logic [7:0] acq_cnt;
	logic sync_m;
	logic sync_s;
	logic sync_d;

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] wd, input logic bw, input logic hi);
		merge = !bw ? wd : (hi ? {wd[7:0], old[7:0]} : {old[15:8], wd[7:0]});
	endfunction

	// register decode
	wire [3:0] word = bus.host_address_lines[ADDR_W-1:1];
	wire byte_hi = bus.byte_wide_bus_select & bus.host_address_lines[0];
	wire is_ram = word <= WORD_INST_MAX;
	wire [IDX_W-1:0] ram_idx = word[IDX_W-1:0];
	wire ram_ok = is_ram && ptr != PTR_NONE;
	wire [1:0] sect = (ptr == PTR_NONE) ? 2'h0 : ptr;
	wire wr = bus.bus_req & bus.bus_we;
	wire [DATA_W-1:0] cfg_img = {6'h00, ptr, sync_dir, 5'h00, 1'b0, running};
	wire [DATA_W-1:0] ram_old = ram[ram_idx][sect];
	wire [DATA_W-1:0] reg_val = ram_ok ? ram_old :
		(word == WORD_CFG) ? cfg_img :
		(word == WORD_TIMER) ? timer_preset : 16'h0000;
	wire [DATA_W-1:0] rd_val = !bus.byte_wide_bus_select ? reg_val :
		(byte_hi ? {8'h00, reg_val[15:8]} : {8'h00, reg_val[7:0]});
	wire [DATA_W-1:0] ram_new = merge(ram_old, bus.bus_wdata,
		bus.byte_wide_bus_select, byte_hi);
	wire [DATA_W-1:0] cfg_new = merge(cfg_img, bus.bus_wdata,
		bus.byte_wide_bus_select, byte_hi);
	wire [DATA_W-1:0] tmr_new = merge(timer_preset, bus.bus_wdata,
		bus.byte_wide_bus_select, byte_hi);
	wire cfg_wr = wr && word == WORD_CFG;
	wire cfg_byte_lo = !bus.byte_wide_bus_select || !byte_hi;
	wire soft_rst = cfg_wr && cfg_byte_lo && cfg_new[CFG_RESET];
	wire start_wr = cfg_wr && cfg_byte_lo;

	// sequencer decode
	wire [DATA_W-1:0] fetched = ram[idx][PTR_CTRL];
	wire pause_hit = armed && fetched[PAUSE_BIT];
	wire halt_now = state == S_FETCH && (pause_hit || !armed || !start);
	wire sync_edge = sync_s & ~sync_d;
	wire wrap = cur[LOOP_BIT] || idx == IDX_LAST;
	wire is_wdog = cur[WDOG_BIT];
	wire issue_from_acq = state == S_ACQ && acq_cnt == 8'h00 && !cur[SYNC_BIT];
	wire issue_from_sync = state == S_SYNC && sync_edge;
	wire second_cmp = state == S_CONV && conv_done && is_wdog && !conv_limit_sel;
	wire issue = issue_from_acq || issue_from_sync || (second_cmp && !cur[SYNC_BIT]);

	// host bus answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus.bus_ack <= 1'b0;
			bus.bus_rdata <= 16'h0000;
		end else begin
			bus.bus_ack <= bus.bus_req;
			bus.bus_rdata <= rd_val;
		end
	end

	// instruction memory, no reset
	always_ff @(posedge aclk) begin
		if (wr && ram_ok) begin
			ram[ram_idx][sect] <= ram_new;
		end
	end

	// configuration and timer preset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_dir <= 1'b0;
			ptr <= PTR_CTRL;
			timer_preset <= 16'h0000;
		end else begin
			if (cfg_wr) begin
				sync_dir <= cfg_new[CFG_SYNC_DIR];
				ptr <= cfg_new[CFG_PTR_LSB +: PTR_W];
			end
			if (wr && word == WORD_TIMER) begin
				timer_preset <= tmr_new;
			end
		end
	end

	// trigger pin synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_m <= 1'b0;
			sync_s <= 1'b0;
			sync_d <= 1'b0;
			sync_oe <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			sync_m <= sync_in;
			sync_s <= sync_m;
			sync_d <= sync_s;
			sync_oe <= sync_dir;
			sync_out <= state == S_CONV;
		end
	end

	// start bit: host write wins over the halt clear
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			start <= 1'b0;
		end else if (start_wr) begin
			start <= cfg_new[CFG_START];
		end else if (state == S_FETCH && pause_hit) begin
			start <= 1'b0;
		end
	end

	// sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			state <= S_FETCH;
			idx <= IDX_FIRST;
			cur <= 16'h0000;
			armed <= 1'b0;
			running <= 1'b0;
			pause_irq <= 1'b0;
			timer_cnt <= 16'h0000;
			acq_cnt <= 8'h00;
			conv_req <= 1'b0;
			conv_limit_sel <= 1'b0;
			conv_limit <= 16'h0000;
			conv_pos_input <= 3'h0;
			conv_neg_input <= 3'h0;
			conv_res_8bit <= 1'b0;
			conv_compare <= 1'b0;
		end else begin
			pause_irq <= 1'b0;
			conv_req <= issue;
			running <= state != S_WAIT && !halt_now;
			if (issue) begin
				conv_limit <= ram[idx][(second_cmp || conv_limit_sel) ? PTR_LIM2 : PTR_LIM1];
			end
			case (state)
				S_FETCH: begin
					cur <= fetched;
					conv_pos_input <= fetched[POS_LSB +: CH_W];
					conv_neg_input <= fetched[NEG_LSB +: CH_W];
					conv_res_8bit <= fetched[RES_BIT];
					conv_compare <= fetched[WDOG_BIT];
					conv_limit_sel <= 1'b0;
					if (pause_hit) begin
						pause_irq <= 1'b1;
						state <= S_WAIT;
					end else if (!armed || !start) begin
						state <= S_WAIT;
					end else begin
						state <= S_EXEC;
					end
				end
				S_WAIT: begin
					if (start) begin
						armed <= 1'b1;
						state <= S_EXEC;
					end
				end
				S_EXEC: begin
					timer_cnt <= timer_preset;
					acq_cnt <= 8'(ACQ_CYCLES - 1);
					state <= cur[TIMER_BIT] ? S_TIMER : S_ACQ;
				end
				S_TIMER: begin
					if (timer_cnt == 16'h0000) begin
						state <= S_ACQ;
					end else begin
						timer_cnt <= timer_cnt - 16'h0001;
					end
				end
				S_ACQ: begin
					if (acq_cnt != 8'h00) begin
						acq_cnt <= acq_cnt - 8'h01;
					end else begin
						state <= cur[SYNC_BIT] ? S_SYNC : S_CONV;
					end
				end
				S_SYNC: begin
					if (sync_edge) begin
						state <= S_CONV;
					end
				end
				S_CONV: begin
					if (second_cmp) begin
						conv_limit_sel <= 1'b1;
						state <= cur[SYNC_BIT] ? S_SYNC : S_CONV;
					end else if (conv_done) begin
						state <= S_NEXT;
					end
				end
				S_NEXT: begin
					idx <= wrap ? IDX_FIRST : idx + 3'h1;
					state <= S_FETCH;
				end
				default: state <= S_FETCH;
			endcase
		end
	end
endmodule

// file: rtl/acqseq_host.sv
`timescale 1ns/10ps
module acqseq_host
	import acqseq_pkg::*;
	(
	input wire logic aclk,
	input wire logic aresetn,
	acqseq_if.host bus,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
	);

	logic [7:0] aw_addr;
	logic aw_got;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_got;
	logic [9:0] ctrl;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic busy;
	logic done;

	wire do_wr = aw_got && w_got && !s_axi_bvalid;
	wire wr_ctrl = do_wr && aw_addr == HOST_CTRL;
	wire wr_wdat = do_wr && aw_addr == HOST_WDATA;
	wire wr_go = do_wr && aw_addr == HOST_GO && !busy;
	wire wr_ok = wr_ctrl || wr_wdat || aw_addr == HOST_GO;
	wire rd_do = s_axi_arvalid && s_axi_arready;
	wire rd_map = s_axi_araddr == HOST_CTRL || s_axi_araddr == HOST_WDATA ||
		s_axi_araddr == HOST_STATUS || s_axi_araddr == HOST_RDATA ||
		s_axi_araddr == HOST_GO;
	wire [31:0] rd_val = (s_axi_araddr == HOST_CTRL) ? {22'h000000, ctrl} :
		(s_axi_araddr == HOST_WDATA) ? {16'h0000, wdata} :
		(s_axi_araddr == HOST_STATUS) ? {30'h00000000, done, busy} :
		(s_axi_araddr == HOST_RDATA) ? {16'h0000, rdata} : 32'h00000000;

	// axi4-lite write side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready = !w_got && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// axi4-lite read side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_do) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// command registers and device bus cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= 10'h000;
			wdata <= 16'h0000;
			rdata <= 16'h0000;
			busy <= 1'b0;
			done <= 1'b0;
			bus.bus_req <= 1'b0;
			bus.bus_we <= 1'b0;
			bus.host_address_lines <= 5'h00;
			bus.byte_wide_bus_select <= 1'b0;
			bus.bus_wdata <= 16'h0000;
		end else begin
			bus.bus_req <= wr_go;
			if (wr_ctrl && w_strb[0]) begin
				ctrl[7:0] <= w_data[7:0];
			end
			if (wr_ctrl && w_strb[1]) begin
				ctrl[9:8] <= w_data[9:8];
			end
			if (wr_wdat) begin
				wdata <= w_data[DATA_W-1:0];
			end
			if (wr_go) begin
				busy <= 1'b1;
				done <= 1'b0;
				bus.bus_we <= ctrl[HC_WE_BIT];
				bus.byte_wide_bus_select <= ctrl[HC_BW_BIT];
				bus.host_address_lines <= ctrl[ADDR_W-1:0];
				bus.bus_wdata <= wdata;
			end else if (busy && bus.bus_ack) begin
				busy <= 1'b0;
				done <= 1'b1;
				rdata <= bus.bus_rdata;
			end
		end
	end
endmodule

// file: sim/acqseq_props.sv
`timescale 1ns/10ps
module acqseq_props
	import acqseq_pkg::*;
	(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic bus_req,
	input wire logic bus_we,
	input wire logic [ADDR_W-1:0] host_address_lines,
	input wire logic byte_wide_bus_select,
	input wire logic bus_ack,
	input wire logic pause_irq,
	input wire logic conv_req,
	input wire logic running
	);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_ACK_NEXT: assert property (bus_req |=> bus_ack)
		else $error("no ack after request");
	AST_ACK_CAUSE: assert property (bus_ack |-> $past(bus_req))
		else $error("ack without request");
	AST_REQ_GAP: assert property (bus_req |=> !bus_req)
		else $error("request while ack pending");
	AST_QUAL_HOLD: assert property (bus_req |=>
		$stable({bus_we, host_address_lines, byte_wide_bus_select}))
		else $error("request qualifiers moved");
	AST_IRQ_PULSE: assert property (pause_irq |=> !pause_irq)
		else $error("halt interrupt too long");
	AST_IRQ_STOPS: assert property (pause_irq |-> !running)
		else $error("running during halt");
	AST_IRQ_FROM_RUN: assert property (pause_irq |-> $past(running))
		else $error("halt without prior run");
	AST_CONV_PULSE: assert property (conv_req |=> !conv_req)
		else $error("conversion request too long");
	cover property (pause_irq);
	cover property (bus_req && byte_wide_bus_select);
	cover property (conv_req ##[1:40] conv_req);
endmodule

// file: sim/acquisition_instruction_sequencer_tb_top.sv
`timescale 1ns/10ps
module acquisition_instruction_sequencer_tb_top;
	import acqseq_pkg::*;
	typedef struct {logic [1:0] ptr; logic [3:0] word; logic [15:0] wd; logic [15:0] ex;} acqseq_row_s;
	logic aclk = 0;
	logic aresetn = 0;
	logic sync_in = 0;
	logic conv_done = 0;
	logic conv_req, conv_res_8bit, conv_compare, conv_limit_sel, pause_irq, running;
	logic [2:0] conv_pos_input, conv_neg_input;
	logic [15:0] conv_limit;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 0, rdata;
	logic [1:0] bresp, rresp;
	logic [1:0] dly = 0;
	logic irq_seen = 0, out_seen = 0;
	logic sync_out, sync_oe;
	logic [24:0] q[$];
	int fails = 0, check_count = 0, cyc = 0;
	acqseq_if bus_if();
	always #12.5 aclk = ~aclk;
	acqseq_device #(.ACQ_CYCLES(1)) acqseq_device_inst (.aclk(aclk), .aresetn(aresetn),
		.bus(bus_if), .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
		.pause_irq(pause_irq),
		.conv_req(conv_req), .conv_pos_input(conv_pos_input), .conv_neg_input(conv_neg_input),
		.conv_res_8bit(conv_res_8bit), .conv_compare(conv_compare),
		.conv_limit_sel(conv_limit_sel), .conv_limit(conv_limit), .conv_done(conv_done),
		.running(running));
	acqseq_host acqseq_host_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus_if),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	acqseq_props acqseq_props_inst (.aclk(aclk), .aresetn(aresetn), .bus_req(bus_if.bus_req),
		.bus_we(bus_if.bus_we), .host_address_lines(bus_if.host_address_lines),
		.byte_wide_bus_select(bus_if.byte_wide_bus_select), .bus_ack(bus_if.bus_ack),
		.pause_irq(pause_irq), .conv_req(conv_req), .running(running));
	task give_verdict();
		if (fails == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// datapath stand-in: records requests, ends each three cycles later
	always @(posedge aclk) begin
		dly <= {dly[0], conv_req};
		conv_done <= dly[1];
		if (conv_req === 1'b1) begin
			q.push_back({conv_compare, conv_limit_sel, conv_res_8bit, conv_pos_input,
				conv_neg_input, conv_limit});
		end
		if (pause_irq === 1'b1) begin
			irq_seen <= 1'b1;
		end
		if (sync_out === 1'b1) begin
			out_seen <= 1'b1;
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (awvalid && !awready || wvalid && !wready);
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// one device access through the host controller registers
	task dev(input logic [4:0] a, input logic we, input logic bw, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [31:0] s;
		logic [1:0] r;
		axi_wr(HOST_CTRL, {22'h0, bw, we, 3'h0, a});
		axi_wr(HOST_WDATA, {16'h0, wd});
		axi_wr(HOST_GO, 32'h0);
		do axi_rd(HOST_STATUS, s, r); while (s[1:0] !== 2'b10);
		axi_rd(HOST_RDATA, s, r);
		rd = s[15:0];
	endtask
	task wr16(input logic [3:0] w, input logic [15:0] d);
		logic [15:0] x;
		dev({w, 1'b0}, 1'b1, 1'b0, d, x);
	endtask
	task rd16(input logic [3:0] w, output logic [15:0] d);
		dev({w, 1'b0}, 1'b0, 1'b0, 16'h0, d);
	endtask
	initial begin
		acqseq_row_s rows[6];
		int n;
		logic [15:0] v;
		logic [31:0] d;
		logic [1:0] r;
		rows = '{'{2'h0, 4'h0, 16'h1111, 16'h1111}, '{2'h0, 4'h7, 16'h7770, 16'h7770},
			'{2'h1, 4'h3, 16'ha5a5, 16'ha5a5}, '{2'h2, 4'h3, 16'h5a5a, 16'h5a5a},
			'{2'h3, 4'h3, 16'hffff, 16'h0000}, '{2'h0, 4'ha, 16'hbeef, 16'h0000}};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			wr16(4'h8, {6'h0, rows[i].ptr, 8'h00});
			wr16(rows[i].word, rows[i].wd);
		end
		foreach (rows[i]) begin
			wr16(4'h8, {6'h0, rows[i].ptr, 8'h00});
			rd16(rows[i].word, v);
			chk(v, rows[i].ex);
		end
		wr16(4'h8, 16'h0080);
		chk(sync_oe, 1'b1);
		wr16(4'h8, 16'h0000);
		dev(5'h0a, 1'b1, 1'b1, 16'h00c3, v);
		dev(5'h0b, 1'b1, 1'b1, 16'h003c, v);
		rd16(4'h5, v);
		chk(v, 16'h3cc3);
		dev(5'h0b, 1'b0, 1'b1, 16'h0000, v);
		chk(v[7:0], 8'h3c);
		axi_rd(8'h40, d, r);
		chk(r, RESP_SLVERR);
		wr16(4'h0, 16'h010e);
		wr16(4'h1, 16'h0ca5);
		wr16(4'h8, 16'h0100);
		wr16(4'h1, 16'h1234);
		wr16(4'h8, 16'h0200);
		wr16(4'h1, 16'h5678);
		wr16(4'h8, 16'h0002);
		chk(running, 0);
		wr16(4'h8, 16'h0001);
		chk(sync_oe, 1'b0);
		repeat (30) @(posedge aclk);
		chk(32'(q.size()), 0);
		sync_in <= 1'b1;
		while (!irq_seen) @(posedge aclk);
		sync_in <= 1'b0;
		chk(32'(q.size()), 3);
		chk(q[0][24:16], {3'b000, 3'h3, 3'h0});
		chk(q[1], {3'b101, 3'h1, 3'h5, 16'h1234});
		chk(q[2], {3'b111, 3'h1, 3'h5, 16'h5678});
		rd16(4'h8, v);
		chk(v[0], 1'b0);
		wr16(4'h8, 16'h0001);
		repeat (30) @(posedge aclk);
		chk(32'(q.size()), 3);
		sync_in <= 1'b1;
		while (q.size() < 4) @(posedge aclk);
		chk(q[3][24:16], {3'b000, 3'h3, 3'h0});
		wr16(4'h8, 16'h0002);
		wr16(4'h8, 16'h0100);
		wr16(4'h0, 16'h0aaa);
		wr16(4'h8, 16'h0200);
		wr16(4'h0, 16'h0bbb);
		wr16(4'h8, 16'h0000);
		wr16(4'h0, 16'h0b05);
		wr16(4'h9, 16'h0060);
		wr16(4'h8, 16'h0002);
		sync_in <= 1'b0;
		n = q.size();
		wr16(4'h8, 16'h0001);
		repeat (30) @(posedge aclk);
		sync_in <= 1'b1;
		repeat (30) @(posedge aclk);
		chk(32'(q.size() - n), 0);
		sync_in <= 1'b0;
		repeat (60) @(posedge aclk);
		sync_in <= 1'b1;
		while (q.size() < n + 1) @(posedge aclk);
		sync_in <= 1'b0;
		repeat (30) @(posedge aclk);
		chk(32'(q.size() - n), 1);
		sync_in <= 1'b1;
		while (q.size() < n + 2) @(posedge aclk);
		chk(q[n], {3'b100, 3'h1, 3'h0, 16'h0aaa});
		chk(q[n + 1], {3'b110, 3'h1, 3'h0, 16'h0bbb});
		chk(out_seen, 1'b1);
		give_verdict();
	end
endmodule
